// File: include/pmsr_pkg.sv
// Package of constants and types for the processor mode control register
`default_nettype none

package pmsr_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int unsigned PMSR_ADDR_W = 8;
    localparam int unsigned PMSR_DATA_W = 16;
    localparam logic [PMSR_ADDR_W-1:0] PMSR_MODE_CTRL_OFFSET = 8'h00;

    typedef struct packed {
        logic [PMSR_ADDR_W-1:0] addr;
        logic [PMSR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pmsr_bus_req_t;

    // ------------------------------------------------------------
    // Register layout, bit 15 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] vector_page_pointer;
        logic rom_map_select;
        logic ram_overlay;
        logic address_visibility;
        logic upper_ram_data_map;
        logic clock_output_disable;
        logic multiply_saturation;
        logic store_saturation;
    } pmsr_mode_t;

    localparam logic [8:0] PMSR_VECTOR_PAGE_POINTER_RESET = 9'h1FF;
    localparam logic PMSR_FLAG_RESET = 1'b0;
    localparam int unsigned PMSR_PAGE_W = 7;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [15:0] PMSR_DUAL_ACCESS_RAM_LO = 16'h0080;
    localparam logic [15:0] PMSR_DUAL_ACCESS_RAM_LOW_HI = 16'h7FFF;
    localparam logic [15:0] PMSR_DUAL_ACCESS_RAM_UP_LO = 16'h8000;
    localparam logic [15:0] PMSR_ROM_LO = 16'hC000;

    // ------------------------------------------------------------
    // Saturation
    // ------------------------------------------------------------
    localparam logic [15:0] PMSR_SAT_POS = 16'h7FFF;
    localparam logic [15:0] PMSR_SAT_NEG = 16'h8000;
    localparam logic [32:0] PMSR_PROD_SAT = 33'h7FFFFFFF;

    typedef enum logic [1:0] {
        PMSR_STRAP_WAIT = 2'b01,
        PMSR_STRAP_RUN = 2'b10
    } pmsr_strap_t;

endpackage : pmsr_pkg

`default_nettype wire

// File: rtl/pmsr_clock_output_pin.sv
// Clock output pin generator with high-level hold
`timescale 1ns/100ps
`default_nettype none

module pmsr_clock_output_pin
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_disable,
    output logic o_clock_output_pin
);
    // ------------------------------------------------------------
    // Half-rate toggle, parked high while disabled
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_clock_output_pin <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_disable)
            begin
                o_clock_output_pin <= 1'b1;
            end
            else
            begin
                o_clock_output_pin <= ~o_clock_output_pin;
            end
        end
    end

endmodule : pmsr_clock_output_pin

`default_nettype wire

// File: rtl/pmsr_top.sv
// Processor mode control register with memory map, pin and saturation control
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module pmsr_top
#(
    parameter int unsigned ACC_W = 40
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire pmsr_pkg::pmsr_bus_req_t i_bus,
    output logic [pmsr_pkg::PMSR_DATA_W-1:0] o_rdata,
    input wire logic i_rom_map_select_pin,
    input wire logic i_soft_reset,
    input wire logic [4:0] i_vector_num,
    output logic [15:0] o_vector_addr,
    input wire logic [15:0] i_prog_addr,
    input wire logic i_prog_valid,
    input wire logic [15:0] i_data_addr,
    output logic o_prog_rom_hit,
    output logic o_prog_dual_access_ram_hit,
    output logic o_data_dual_access_ram_hit,
    input wire logic [15:0] i_ext_addr,
    input wire logic i_ext_valid,
    output logic [15:0] o_address_pins,
    output logic o_clock_output_pin,
    input wire logic i_overflow_mode,
    input wire logic i_fractional_mode,
    input wire logic i_mul_valid,
    input wire logic signed [15:0] i_mul_a,
    input wire logic signed [15:0] i_mul_b,
    output logic [32:0] o_product,
    input wire logic i_store_valid,
    input wire logic signed [ACC_W-1:0] i_acc,
    input wire logic signed [4:0] i_store_shift,
    output logic [15:0] o_store_data,
    output pmsr_pkg::pmsr_mode_t o_mode
);
    import pmsr_pkg::*;

    localparam int unsigned EXT_W = ACC_W + 16;

    if (ACC_W < 17 || ACC_W > 48)
    begin : g_bad_acc
        $error("ACC_W must be 17 to 48");
    end

    pmsr_mode_t mode;
    pmsr_strap_t strap_state;
    logic pin_meta;
    logic pin_sync;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [15:0] sat16(input logic signed [EXT_W-1:0] v, input logic en);
        logic signed [EXT_W-1:0] lim_pos;
        logic signed [EXT_W-1:0] lim_neg;
        lim_pos = EXT_W'(signed'(PMSR_SAT_POS));
        lim_neg = {{(EXT_W-16){1'b1}}, PMSR_SAT_NEG};
        if (en && v > lim_pos)
            sat16 = PMSR_SAT_POS;
        else if (en && v < lim_neg)
            sat16 = PMSR_SAT_NEG;
        else
            sat16 = v[15:0];
    endfunction : sat16

    assign wr_hit = i_bus.wr && (i_bus.addr == PMSR_MODE_CTRL_OFFSET);
    assign rd_hit = i_bus.rd && (i_bus.addr == PMSR_MODE_CTRL_OFFSET);
    assign o_mode = mode;

    // ------------------------------------------------------------
    // Strap pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            pin_meta <= i_rom_map_select_pin;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------
    // Strap capture, once per hardware reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            strap_state <= PMSR_STRAP_WAIT;
        end
        else if (i_ce)
        begin
            case (strap_state)
                PMSR_STRAP_WAIT: strap_state <= PMSR_STRAP_RUN;
                PMSR_STRAP_RUN: strap_state <= PMSR_STRAP_RUN;
                default: strap_state <= PMSR_STRAP_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mode.vector_page_pointer <= PMSR_VECTOR_PAGE_POINTER_RESET;
            mode.rom_map_select <= PMSR_FLAG_RESET;
            mode.ram_overlay <= PMSR_FLAG_RESET;
            mode.address_visibility <= PMSR_FLAG_RESET;
            mode.upper_ram_data_map <= PMSR_FLAG_RESET;
            mode.clock_output_disable <= PMSR_FLAG_RESET;
            mode.multiply_saturation <= PMSR_FLAG_RESET;
            mode.store_saturation <= PMSR_FLAG_RESET;
        end
        else if (i_ce)
        begin
            if (wr_hit)
            begin
                mode <= pmsr_mode_t'(i_bus.wdata);
            end
            if (i_soft_reset)
            begin
                // Pointer, ROM map and both saturation bits kept
                mode.ram_overlay <= PMSR_FLAG_RESET;
                mode.address_visibility <= PMSR_FLAG_RESET;
                mode.upper_ram_data_map <= PMSR_FLAG_RESET;
                mode.clock_output_disable <= PMSR_FLAG_RESET;
            end
            if (strap_state == PMSR_STRAP_WAIT)
            begin
                mode.rom_map_select <= pin_sync;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_rdata <= '0;
        else if (i_ce)
            o_rdata <= rd_hit ? PMSR_DATA_W'(mode) : '0;
    end

    // ------------------------------------------------------------
    // Vector address
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_vector_addr <= {PMSR_VECTOR_PAGE_POINTER_RESET, 7'h00};
        else if (i_ce)
            o_vector_addr <= {mode.vector_page_pointer, i_vector_num, 2'b00};
    end

    // ------------------------------------------------------------
    // Memory map decode
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_prog_rom_hit <= 1'b0;
            o_prog_dual_access_ram_hit <= 1'b0;
            o_data_dual_access_ram_hit <= 1'b0;
        end
        else if (i_ce)
        begin
            o_prog_rom_hit <= !mode.rom_map_select && (i_prog_addr >= PMSR_ROM_LO);
            o_prog_dual_access_ram_hit <= mode.ram_overlay
                && in_range(i_prog_addr, PMSR_DUAL_ACCESS_RAM_LO, PMSR_DUAL_ACCESS_RAM_LOW_HI);
            o_data_dual_access_ram_hit <= in_range(i_data_addr, PMSR_DUAL_ACCESS_RAM_LO, PMSR_DUAL_ACCESS_RAM_LOW_HI)
                || (mode.upper_ram_data_map && i_data_addr >= PMSR_DUAL_ACCESS_RAM_UP_LO);
        end
    end

    // ------------------------------------------------------------
    // External address pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_address_pins <= '0;
        else if (i_ce)
        begin
            if (i_ext_valid)
                o_address_pins <= i_ext_addr;
            else if (mode.address_visibility && i_prog_valid)
                o_address_pins <= i_prog_addr;
            // Otherwise last address held
        end
    end

    // ------------------------------------------------------------
    // Clock output pin
    // ------------------------------------------------------------
    pmsr_clock_output_pin u_clock_output_pin
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_disable(mode.clock_output_disable),
        .o_clock_output_pin(o_clock_output_pin)
    );

    // ------------------------------------------------------------
    // Multiplier with product saturation
    // ------------------------------------------------------------
    logic signed [32:0] next_product;
    always_comb
    begin
        next_product = 33'(i_mul_a * i_mul_b);
        if (i_fractional_mode)
            next_product = next_product <<< 1;
        if (mode.multiply_saturation && i_overflow_mode && i_fractional_mode
            && i_mul_a == PMSR_SAT_NEG && i_mul_b == PMSR_SAT_NEG)
            next_product = PMSR_PROD_SAT;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_product <= '0;
        else if (i_ce && i_mul_valid)
            o_product <= next_product;
    end

    // ------------------------------------------------------------
    // Store path: shift, then saturate
    // ------------------------------------------------------------
    logic signed [EXT_W-1:0] next_shifted;
    always_comb
    begin
        if (i_store_shift >= 0)
            next_shifted = EXT_W'(i_acc) <<< i_store_shift;
        else
            next_shifted = EXT_W'(i_acc) >>> 6'(-i_store_shift);
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_store_data <= '0;
        else if (i_ce && i_store_valid)
            o_store_data <= sat16(next_shifted, mode.store_saturation);
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_vec_write;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && wr_hit && !i_soft_reset) |=> mode.vector_page_pointer == $past(i_bus.wdata[15:7]);
    endproperty
    a_vec_write: assert property (p_vec_write) else $error("vector page not loaded");

    property p_reset_page;
        @(posedge i_clk) disable iff (i_reset)
        $fell(strap_state == PMSR_STRAP_WAIT) |-> $past(mode.vector_page_pointer) == PMSR_VECTOR_PAGE_POINTER_RESET;
    endproperty
    a_reset_page: assert property (p_reset_page) else $error("vector page not all ones at reset");

    property p_soft_keep;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_soft_reset && !wr_hit && strap_state == PMSR_STRAP_RUN)
        |=> $stable(mode.vector_page_pointer) && $stable(mode.rom_map_select);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset altered kept fields");

    property p_strap_once;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !wr_hit && strap_state == PMSR_STRAP_RUN) |=> $stable(mode.rom_map_select);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("ROM map bit changed without write");

    property p_page0_out;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && (i_prog_addr < PMSR_DUAL_ACCESS_RAM_LO || !mode.ram_overlay)) |=> !o_prog_dual_access_ram_hit;
    endproperty
    a_page0_out: assert property (p_page0_out) else $error("dual RAM wrongly in program space");

    property p_addr_hold;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !i_ext_valid && !mode.address_visibility) |=> $stable(o_address_pins);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address pins moved");

    property p_addr_trace;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !i_ext_valid && mode.address_visibility && i_prog_valid)
        |=> o_address_pins == $past(i_prog_addr);
    endproperty
    a_addr_trace: assert property (p_addr_trace) else $error("program address not traced");

    property p_upper_data;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_data_addr >= PMSR_DUAL_ACCESS_RAM_UP_LO) |=> o_data_dual_access_ram_hit == $past(mode.upper_ram_data_map);
    endproperty
    a_upper_data: assert property (p_upper_data) else $error("upper dual RAM decode wrong");

    property p_clk_high;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode.clock_output_disable) |=> o_clock_output_pin;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock pin not parked high");

    property p_mul_sat;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_mul_valid && i_mul_a == PMSR_SAT_NEG && i_mul_b == PMSR_SAT_NEG && i_fractional_mode)
        |=> o_product == ((($past(mode.multiply_saturation && i_overflow_mode))) ? PMSR_PROD_SAT : 33'h80000000);
    endproperty
    a_mul_sat: assert property (p_mul_sat) else $error("product saturation wrong");

    property p_store_sat;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_store_valid && mode.store_saturation && i_store_shift == 5'sd0 && i_acc > 0
            && i_acc[ACC_W-2:15] != '0) |=> o_store_data == PMSR_SAT_POS;
    endproperty
    a_store_sat: assert property (p_store_sat) else $error("store not saturated");

    property p_cv_write;
        @(posedge i_clk) disable iff (i_reset) i_ce && wr_hit;
    endproperty
    c_cv_write: cover property (p_cv_write);

    property p_cv_trace;
        @(posedge i_clk) disable iff (i_reset) i_ce && mode.address_visibility && i_prog_valid && !i_ext_valid;
    endproperty
    c_cv_trace: cover property (p_cv_trace);

    property p_cv_soft;
        @(posedge i_clk) disable iff (i_reset) i_ce && i_soft_reset && mode.ram_overlay;
    endproperty
    c_cv_soft: cover property (p_cv_soft);

endmodule : pmsr_top

`default_nettype wire

// File: verification/test_pmsr_top.sv
// Self-checking testbench of the processor mode control register
`timescale 1ns/100ps
`default_nettype none

module test_pmsr_top;
    import pmsr_pkg::*;

    logic i_clk, i_reset, i_ce, i_rom_map_select_pin, i_soft_reset;
    pmsr_bus_req_t i_bus;
    logic [15:0] o_rdata, o_vector_addr, o_address_pins, o_store_data;
    logic [4:0] i_vector_num;
    logic [15:0] i_prog_addr, i_data_addr, i_ext_addr;
    logic i_prog_valid, i_ext_valid, i_overflow_mode, i_fractional_mode, i_mul_valid, i_store_valid;
    logic o_prog_rom_hit, o_prog_dual_access_ram_hit, o_data_dual_access_ram_hit, o_clock_output_pin;
    logic signed [15:0] i_mul_a, i_mul_b;
    logic [32:0] o_product;
    logic signed [39:0] i_acc;
    logic signed [4:0] i_store_shift;
    pmsr_mode_t o_mode;
    int fail_count = 0;
    int samples_checked = 0;

    pmsr_top dut (.i_clk, .i_reset, .i_ce, .i_bus, .o_rdata, .i_rom_map_select_pin, .i_soft_reset,
        .i_vector_num, .o_vector_addr, .i_prog_addr, .i_prog_valid, .i_data_addr, .o_prog_rom_hit,
        .o_prog_dual_access_ram_hit, .o_data_dual_access_ram_hit, .i_ext_addr, .i_ext_valid, .o_address_pins,
        .o_clock_output_pin, .i_overflow_mode, .i_fractional_mode, .i_mul_valid, .i_mul_a, .i_mul_b,
        .o_product, .i_store_valid, .i_acc, .i_store_shift, .o_store_data, .o_mode);

    // ------------------------------------------------------------
    // Clock and common tasks
    // ------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic check_val(input string what, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus.wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus.rd <= 1'b0;
        #1;
        check_val("read data", exp, o_rdata);
        tick(1);
        check_val("read data one cycle on", 16'h0000, o_rdata);
    endtask : reg_read

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic do_reset(input logic pin, input logic [15:0] exp);
        i_rom_map_select_pin <= pin;
        i_vector_num <= 5'd0;
        i_reset <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        tick(2);
        check_val("mode after reset", exp, o_mode);
        check_val("reset vector", 16'hFF80, o_vector_addr);
    endtask : do_reset

    task automatic t_regs;
        reg_write(8'h00, 16'h0080);
        check_val("mode", 16'h0080, o_mode);
        @(posedge i_clk);
        i_vector_num <= 5'd3;
        tick(1);
        check_val("vector address", 16'h008C, o_vector_addr);
        reg_read(8'h00, 16'h0080);
        reg_write(8'h04, 16'hFFFF);
        check_val("mode after unmapped write", 16'h0080, o_mode);
        reg_read(8'h04, 16'h0000);
        @(posedge i_clk);
        i_ce <= 1'b0;
        reg_write(8'h00, 16'hFFFF);
        @(posedge i_clk);
        i_ce <= 1'b1;
        tick(1);
        check_val("mode after frozen write", 16'h0080, o_mode);
    endtask : t_regs

    task automatic t_soft;
        reg_write(8'h00, 16'hFFFF);
        @(posedge i_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_clk);
        i_soft_reset <= 1'b0;
        #1;
        check_val("mode after soft reset", 16'hFFC3, o_mode);
        @(posedge i_clk);
        i_rom_map_select_pin <= 1'b0;
        tick(4);
        check_val("mode after pin change", 16'hFFC3, o_mode);
        reg_write(8'h00, 16'hFF83);
        check_val("mode after rom clear", 16'hFF83, o_mode);
    endtask : t_soft

    task automatic t_decode;
        logic [15:0] m[5] = '{16'hFF80, 16'hFFC0, 16'hFFA0, 16'hFFA0, 16'hFF88};
        logic [15:0] pa[5] = '{16'hC000, 16'hC000, 16'h0100, 16'h0040, 16'h0100};
        logic [15:0] da[5] = '{16'h8000, 16'h0100, 16'h0040, 16'h9000, 16'h9000};
        logic [2:0] ex[5] = '{3'b100, 3'b001, 3'b010, 3'b000, 3'b001};
        for (int k = 0; k < 5; k++)
        begin
            reg_write(8'h00, m[k]);
            @(posedge i_clk);
            i_prog_addr <= pa[k];
            i_prog_valid <= 1'b1;
            i_data_addr <= da[k];
            tick(1);
            check_val("decode hits", ex[k], {o_prog_rom_hit, o_prog_dual_access_ram_hit, o_data_dual_access_ram_hit});
        end
    endtask : t_decode

    task automatic t_vis;
        reg_write(8'h00, 16'hFF80);
        @(posedge i_clk);
        i_ext_addr <= 16'h1234;
        i_ext_valid <= 1'b1;
        i_prog_addr <= 16'h4321;
        @(posedge i_clk);
        i_ext_valid <= 1'b0;
        tick(3);
        check_val("address pins hold", 16'h1234, o_address_pins);
        reg_write(8'h00, 16'hFF90);
        tick(1);
        check_val("address pins trace", 16'h4321, o_address_pins);
    endtask : t_vis

    task automatic t_clk;
        logic first;
        reg_write(8'h00, 16'hFF80);
        tick(2);
        first = o_clock_output_pin;
        tick(1);
        check_val("clock pin toggles", {~first}, o_clock_output_pin);
        reg_write(8'h00, 16'hFF84);
        tick(2);
        repeat (4)
        begin
            check_val("clock pin parked", 1'b1, o_clock_output_pin);
            tick(1);
        end
    endtask : t_clk

    task automatic t_mul;
        logic [15:0] m[4] = '{16'hFF82, 16'hFF82, 16'hFF82, 16'hFF80};
        logic [1:0] of[4] = '{2'b11, 2'b01, 2'b10, 2'b11};
        logic [32:0] ex[4] = '{33'h7FFFFFFF, 33'h80000000, 33'h40000000, 33'h80000000};
        for (int k = 0; k < 4; k++)
        begin
            reg_write(8'h00, m[k]);
            @(posedge i_clk);
            i_overflow_mode <= of[k][1];
            i_fractional_mode <= of[k][0];
            i_mul_a <= 16'sh8000;
            i_mul_b <= 16'sh8000;
            i_mul_valid <= 1'b1;
            @(posedge i_clk);
            i_mul_valid <= 1'b0;
            #1;
            check_val("product", ex[k], o_product);
        end
    endtask : t_mul

    task automatic t_store;
        logic [15:0] m[6] = '{16'hFF81, 16'hFF81, 16'hFF81, 16'hFF81, 16'hFF80, 16'hFF80};
        logic [39:0] ac[6] = '{40'h0000010000, 40'h0000004000, 40'hFFFFFF0000,
                               40'h0000004000, 40'h0000012345, 40'h0000004000};
        logic [4:0] sh[6] = '{5'h00, 5'h01, 5'h00, 5'h1F, 5'h00, 5'h01};
        logic [15:0] ex[6] = '{16'h7FFF, 16'h7FFF, 16'h8000, 16'h2000, 16'h2345, 16'h8000};
        for (int k = 0; k < 6; k++)
        begin
            reg_write(8'h00, m[k]);
            @(posedge i_clk);
            i_acc <= ac[k];
            i_store_shift <= sh[k];
            i_store_valid <= 1'b1;
            @(posedge i_clk);
            i_store_valid <= 1'b0;
            #1;
            check_val("store data", ex[k], o_store_data);
        end
    endtask : t_store

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        $display("CHECK FAILED watchdog expected end of run seen timeout");
        conclude();
    end

    initial
    begin
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_bus = '0;
        i_rom_map_select_pin = 1'b1;
        i_soft_reset = 1'b0;
        i_vector_num = 5'd0;
        i_prog_addr = 16'h0000;
        i_prog_valid = 1'b0;
        i_data_addr = 16'h0000;
        i_ext_addr = 16'h0000;
        i_ext_valid = 1'b0;
        i_overflow_mode = 1'b0;
        i_fractional_mode = 1'b0;
        i_mul_valid = 1'b0;
        i_mul_a = 16'sh0000;
        i_mul_b = 16'sh0000;
        i_store_valid = 1'b0;
        i_acc = 40'sh0;
        i_store_shift = 5'sh00;
        do_reset(1'b1, 16'hFFC0);
        t_regs();
        t_soft();
        t_decode();
        t_vis();
        t_clk();
        t_mul();
        t_store();
        do_reset(1'b0, 16'hFF80);
        conclude();
    end

endmodule : test_pmsr_top

`default_nettype wire
